// ==== rtl/fdi_filt.sv ====
// Fixed delay filter for one input channel.
// Assumes raw is already synchronised to clk_i.
`timescale 1ns/1ps
`default_nettype none
module fdi_filt
(
   input  wire logic   clk_i,   // System clock
   input  wire logic   reset_i, // Synchronous reset
   fdi_filt_if.filt    ch       // Channel link
);
   logic [fdi_pkg::CNT_W-1:0] cnt;
   logic [fdi_pkg::CNT_W-1:0] next_cnt;
   logic                      state;
   logic                      next_state;

   // Level must differ for full delay before it is taken; glitches restart it
   always_comb
   begin
      next_cnt   = '0;
      next_state = state;
      if (ch.raw != state)
      begin
         if (cnt == fdi_pkg::CNT_W'(fdi_pkg::DELAY_CYCLES - 1))
            next_state = ch.raw;
         else
            next_cnt = cnt + 1'b1;
      end
   end

   // Register stage
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         cnt   <= '0;
         state <= 1'b0;
      end
      else
      begin
         cnt   <= next_cnt;
         state <= next_state;
      end
   end

   assign ch.clean = state;
endmodule : fdi_filt
`default_nettype wire

// ==== rtl/fdi_filt_if.sv ====
// Interface joining the top to one channel's delay filter.
// Assumes one clock domain for both ends.
`timescale 1ns/1ps
`default_nettype none
interface fdi_filt_if;
   logic raw;   // Synchronised input level
   logic clean; // Delayed, stable level
   modport filt (input raw, output clean);
   modport top  (output raw, input clean);
endinterface : fdi_filt_if
`default_nettype wire

// ==== rtl/fdi_pkg.sv ====
// Constants for the four channel digital input block.
// Assumes a 100 MHz clk_i and a synchronous active-high reset.
// Functional notes
// - Input image byte at address zero, bits 3..0 are inputs 3..0.
// - No output image bytes; writes toward output area have no effect.
// - Both edges of each input reach the image only after 3 ms.
// - Channel indicator lit while its input reads one, dark on zero.
// - Channel indicators keep tracking inputs with electronics power off.
// - Run indicator on while backplane communication works, off otherwise.
// - Fault indicator follows module error status, independent of run indicator.
// - Bus power fault holds both run and fault indicators off.
// - All four inputs sampled and reported together, in any orientation.
package fdi_pkg;
   localparam int unsigned NUM_CH       = 4;
   localparam int unsigned IMG_W        = 8;
   localparam logic [7:0]  IMG_OFFSET   = 8'h00;
   localparam logic [7:0]  IMG_RESET    = 8'h00;
   localparam int unsigned CLK_MHZ      = 100;
   localparam int unsigned DELAY_US     = 3000;
   // Least time rounds up; 100 MHz gives exact whole cycles
   localparam int unsigned DELAY_CYCLES = (DELAY_US * CLK_MHZ * 1000 + 999) / 1000;
   localparam int unsigned CNT_W        = $clog2(DELAY_CYCLES + 1);
endpackage : fdi_pkg

// ==== rtl/fdi_top.sv ====
// Four channel digital input with process input image and indicators.
// Assumes bus status levels come from backplane logic on clk_i.
`timescale 1ns/1ps
`default_nettype none
module fdi_top
(
   input  wire logic       clk_i,             // System clock
   input  wire logic       reset_i,           // Synchronous reset
   input  wire logic [3:0] input_channel_i,   // Field inputs, asynchronous
   input  wire logic       bus_comm_ok_i,     // Backplane communication works
   input  wire logic       module_error_i,    // Module status reports error
   input  wire logic       bus_power_fault_i, // Bus power supply fault
   input  wire logic [7:0] out_wdata_i,       // Output area write data, unused
   input  wire logic       out_wr_i,          // Output area write strobe, unused
   output logic [7:0]      process_input_image_o,  // Image byte at offset 0
   output logic [3:0]      channel_led_o,          // Green per-channel LEDs
   output logic            run_led_o,              // Green run LED
   output logic            module_fault_indicator_o // Red fault LED
);
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic [3:0] clean;
   logic [7:0] next_image;
   logic [3:0] next_ch_led;
   logic       next_run;
   logic       next_fault;

   // Two-flop synchroniser, all channels captured on the same edge
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         sync1 <= '0;
         sync2 <= '0;
      end
      else
      begin
         sync1 <= input_channel_i;
         sync2 <= sync1;
      end
   end

   // One filter per channel
   genvar g;
   generate
      for (g = 0; g < fdi_pkg::NUM_CH; g++)
      begin : g_ch
         fdi_filt_if fi ();
         assign fi.raw   = sync2[g];
         assign clean[g] = fi.clean;
         fdi_filt u_filt
         (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .ch      (fi.filt)
         );
      end
   endgenerate

   // Output area is not decoded: no byte exists, writes are dropped
   logic unused_out;
   assign unused_out = ^{out_wdata_i, out_wr_i};

   // Next image and indicators
   always_comb
   begin
      next_image  = {4'h0, clean};
      next_ch_led = clean;
      // Channel LEDs do not depend on bus or power status
      next_run    = bus_comm_ok_i && !bus_power_fault_i;
      next_fault  = module_error_i && !bus_power_fault_i;
   end

   // Output registers
   always_ff @(posedge clk_i)
   begin
      if (reset_i)
      begin
         process_input_image_o    <= fdi_pkg::IMG_RESET;
         channel_led_o            <= '0;
         run_led_o                <= 1'b0;
         module_fault_indicator_o <= 1'b0;
      end
      else
      begin
         process_input_image_o    <= next_image;
         channel_led_o            <= next_ch_led;
         run_led_o                <= next_run;
         module_fault_indicator_o <= next_fault;
      end
   end
endmodule : fdi_top
`default_nettype wire

// ==== sim/fdi_head_model.sv ====
// Head module model that maps the image byte.
// Same clock as fdi_top.
`timescale 1ns/1ps
`default_nettype none
module fdi_head_model
(
   input  wire logic       clk_i,   // Clock
   input  wire logic [7:0] image_i, // Image byte
   output logic [7:0]      mapped_o // Mapped copy
);
   // Reader ignores the reserved nibble
   always_ff @(posedge clk_i)
      mapped_o <= {4'h0, image_i[3:0]};
endmodule : fdi_head_model
`default_nettype wire

// ==== sim/fdi_properties.sv ====
// Port checks for fdi_top.
// Bound to every fdi_top instance.
`timescale 1ns/1ps
`default_nettype none
module fdi_props
(
   input wire logic       clk_i,                   // Clock
   input wire logic       reset_i,                 // Reset
   input wire logic       bus_comm_ok_i,           // Comm
   input wire logic       module_error_i,          // Error
   input wire logic       bus_power_fault_i,       // Power
   input wire logic [7:0] process_input_image_o,   // Image
   input wire logic [3:0] channel_led_o,           // LEDs
   input wire logic       run_led_o,               // Run
   input wire logic       module_fault_indicator_o // Fault
);
   // Outputs are registered, so checks look one edge on
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_upper_zero: assert property (process_input_image_o[7:4] == 4'h0)
      else $error("upper bits");
   a_led_image: assert property (channel_led_o == process_input_image_o[3:0])
      else $error("led");
   a_run_follow: assert property (1'b1 |=> run_led_o == $past(bus_comm_ok_i && !bus_power_fault_i))
      else $error("run");
   a_fault_follow: assert property (1'b1 |=> module_fault_indicator_o == $past(module_error_i && !bus_power_fault_i))
      else $error("fault");
   a_power_dark: assert property (bus_power_fault_i |=> !run_led_o && !module_fault_indicator_o)
      else $error("power");
   a_image_steady: assert property ($changed(process_input_image_o) |=> $stable(process_input_image_o)[*8])
      else $error("glitch");
   a_image_reset: assert property ($fell(reset_i) |-> process_input_image_o == 8'h00 && channel_led_o == 4'h0)
      else $error("image reset");
   a_lamp_reset: assert property ($fell(reset_i) |-> !run_led_o && !module_fault_indicator_o)
      else $error("lamp reset");
   cover property ($rose(process_input_image_o[0]));
   cover property ($rose(run_led_o));
   cover property ($rose(module_fault_indicator_o));
endmodule : fdi_props
bind fdi_top fdi_props chk_u (.*);
`default_nettype wire

// ==== sim/fdi_top_bench.sv ====
// Bench for fdi_top; filter needs 300k cycles.
// Inputs driven at falling edge.
`timescale 1ns/1ps
`default_nettype none
module fdi_top_bench;
   logic       clk_i, reset_i, ok, er, pf, wr;
   logic [3:0] ch, led;
   logic [7:0] wd, img, map;
   logic       run, mf;
   int         err_total, tests_run;
   fdi_top dut (.clk_i(clk_i), .reset_i(reset_i), .input_channel_i(ch), .bus_comm_ok_i(ok),
      .module_error_i(er), .bus_power_fault_i(pf), .out_wdata_i(wd), .out_wr_i(wr),
      .process_input_image_o(img), .channel_led_o(led), .run_led_o(run),
      .module_fault_indicator_o(mf));
   fdi_head_model head (.clk_i(clk_i), .image_i(img), .mapped_o(map));
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      tests_run++;
      if (g !== e)
      begin
         err_total++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic close_out;
      if (err_total == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // Every status combination
   task automatic t_status;
      for (int i = 0; i < 8; i++)
      begin
         {ok, er, pf} = 3'(i);
         repeat (2) @(negedge clk_i);
         chk("run", {7'h0, ok & ~pf}, {7'h0, run});
         chk("fault", {7'h0, er & ~pf}, {7'h0, mf});
      end
   endtask : t_status
   // Short pulse with output writes must vanish
   task automatic t_glitch;
      {ch, wr, wd, ok, er, pf} = {4'hf, 1'b1, 8'hff, 3'h4};
      repeat (100) @(negedge clk_i);
      {ch, wr} = 5'h00;
      repeat (10) @(negedge clk_i);
      chk("glitch", 8'h00, img);
   endtask : t_glitch
   // Channels 0 and 2 cross the full delay together
   task automatic t_delay;
      ch = 4'h5;
      repeat (299990) @(negedge clk_i);
      chk("early", 8'h00, img);
      repeat (20) @(negedge clk_i);
      chk("image", 8'h05, img);
      chk("led", 8'h05, {4'h0, led});
      chk("mapped", 8'h05, map);
      // Falling edge must wait the same full delay
      ch = 4'h0;
      repeat (299990) @(negedge clk_i);
      chk("fall early", 8'h05, img);
      repeat (20) @(negedge clk_i);
      chk("fall image", 8'h00, img);
      chk("fall led", 8'h00, {4'h0, led});
   endtask : t_delay
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Watchdog well past the two 3 ms runs
   initial
   begin
      #7000000;
      err_total++;
      close_out();
   end
   initial
   begin
      {err_total, tests_run} = 0;
      {reset_i, ch, ok, er, pf, wr, wd} = {1'b1, 4'h0, 4'h0, 8'h00};
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      reset_i = 1'b0;
      chk("reset", 8'h00, img);
      t_status();
      t_glitch();
      t_delay();
      close_out();
   end
endmodule : fdi_top_bench
`default_nettype wire
